// ### src/imb_master_collision.sv
// Operation
// - Released one read low is lost arbitration, except the ack bit after a written byte
// - Collision sets flag, returns to idle
// - Byte collision clears full flag, frees lines
// - Sequence collision aborts and clears enables
// - Stop seen after collision sets event
// - New buffer write restarts at first bit
// - Lines low at start means collision
// - Start counts with SDA high, SCL low collides
// - SDA low in start count drives early
// - Second start count ignores SCL, then SCL low
// - Repeated start checks SDA at SCL high
// - SDA falling in repeated count is fine
// - SCL falling before own SDA low collides
// - Repeated start drives SDA, then SCL low
// - Stop drives SDA low, releases SCL, counts
// - SDA low at stop timeout collides
// - SCL low during stop high collides
// - Count suspended until released SCL reads high
// - Disable or reset clears start, stop seen
//
// Our own choices: the register addresses and the plain strobed port.
`timescale 1ns/100ps
module imb_master_collision (
  // Clock, reset, enable
  input  wire logic                clk_in,
  input  wire logic                arst_n_in,
  input  wire logic                ce_in,
  // Register port
  input  wire imb_pkg::imb_req_type req_in,
  output logic [7:0]               rdata_out,
  // Bus pins
  input  wire logic                sda_in,
  input  wire logic                scl_in,
  output logic                     sda_out,
  output logic                     sda_oe_out,
  output logic                     scl_out,
  output logic                     scl_oe_out
);
  import imb_pkg::*;

  imb_regs_type q;
  imb_regs_type n;
  logic [1:0]   rst_sy;
  logic         rst_n;
  logic         col;
  logic         sda_s;
  logic         scl_s;
  logic         tz;
  logic         start_det;
  logic         stop_det;
  logic         ready;
  logic         last;

  // Reset release synchroniser
  always_ff @(posedge clk_in or negedge arst_n_in) begin
    if (!arst_n_in) begin
      rst_sy <= 2'h0;
    end else if (ce_in) begin
      rst_sy <= {rst_sy[0], 1'b1};
    end
  end
  assign rst_n = rst_sy[1];

  // Next-state logic
  always_comb begin
    n = q;
    col = 1'b0;
    // Pin synchronisers, second stage is the only reader of the first
    n.sda_sy = {q.sda_sy[0], sda_in};
    n.scl_sy = {q.scl_sy[0], scl_in};
    sda_s = q.sda_sy[1];
    scl_s = q.scl_sy[1];
    n.sda_p = sda_s;
    n.scl_p = scl_s;
    start_det = scl_s & q.scl_p & q.sda_p & ~sda_s;
    stop_det = scl_s & q.scl_p & ~q.sda_p & sda_s;
    tz = (q.cnt == CNT_ZERO);
    if (!tz) begin
      n.cnt = q.cnt - CNT_ONE;
    end
    ready = q.en & (q.st == ST_IDLE) & ~(q.sen | q.rsen | q.pen | q.acken);
    last = (q.left == BITS_ONE);
    n.rdata = 8'h00;

    // Register reads
    if (req_in.rd) begin
      case (req_in.addr)
        REG_CTRL: n.rdata = {2'h0, q.ackdt, q.acken, q.pen, q.rsen, q.sen, q.en};
        REG_STATUS: n.rdata = {1'b0, ~ready, q.ackstat, q.p_seen, q.s_seen,
                               q.bf, q.evt, q.bcl};
        REG_DATA: n.rdata = q.tbuf;
        default: n.rdata = {1'b0, q.rate};
      endcase
    end

    // Register writes
    if (req_in.wr) begin
      case (req_in.addr)
        REG_CTRL: begin
          n.en = req_in.wdata[CTRL_EN];
          n.ackdt = req_in.wdata[CTRL_ACKDT];
          if (ready) begin
            n.sen = req_in.wdata[CTRL_SEN];
            n.rsen = req_in.wdata[CTRL_RSEN];
            n.pen = req_in.wdata[CTRL_PEN];
            n.acken = req_in.wdata[CTRL_ACKEN];
          end
        end
        REG_STATUS: begin
          if (req_in.wdata[STAT_BCL]) n.bcl = 1'b0;
          if (req_in.wdata[STAT_EVT]) n.evt = 1'b0;
        end
        REG_DATA: begin
          if (ready) begin
            n.tbuf = req_in.wdata;
            n.bf = 1'b1;
            n.sh = {req_in.wdata, 1'b1};
            n.left = BITS_BYTE;
            n.is_ack = 1'b0;
            n.hold_sda = 1'b0;
            n.cnt = q.rate;
            n.st = ST_T_LOW;
          end
        end
        default: n.rate = req_in.wdata[RATE_W-1:0];
      endcase
    end

    // Sequencer
    case (q.st)
      ST_IDLE: begin
        if (q.en && q.sen) begin
          if (!sda_s || !scl_s) begin
            col = 1'b1;
          end else begin
            n.cnt = q.rate;
            n.st = ST_S_CNT;
          end
        end else if (q.en && q.rsen) begin
          n.cnt = q.rate;
          n.st = ST_R_SDA;
        end else if (q.en && q.pen) begin
          n.st = ST_P_LOW;
        end else if (q.en && q.acken) begin
          n.sh = {q.ackdt, 8'h00};
          n.left = BITS_ACK;
          n.is_ack = 1'b1;
          n.cnt = q.rate;
          n.st = ST_T_LOW;
        end
      end
      ST_S_CNT: begin
        if (!scl_s && sda_s) begin
          col = 1'b1;
        end else if (!sda_s || tz) begin
          n.cnt = q.rate;
          n.st = ST_S_HOLD;
        end
      end
      ST_S_HOLD: begin
        if (tz) begin
          n.hold_sda = 1'b1;
          n.hold_scl = 1'b1;
          n.sen = 1'b0;
          n.evt = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_R_SDA: begin
        if (!sda_s) begin
          n.cnt = q.rate;
        end else if (tz) begin
          n.st = ST_R_SCL;
        end
      end
      ST_R_SCL: begin
        n.cnt = q.rate;
        if (scl_s) begin
          if (!sda_s) begin
            col = 1'b1;
          end else begin
            n.st = ST_R_CNT;
          end
        end
      end
      ST_R_CNT: begin
        if (!scl_s) begin
          col = 1'b1;
        end else if (tz) begin
          n.cnt = q.rate;
          n.st = ST_R_HOLD;
        end
      end
      ST_R_HOLD: begin
        if (tz) begin
          n.hold_sda = 1'b1;
          n.hold_scl = 1'b1;
          n.rsen = 1'b0;
          n.evt = 1'b1;
          n.st = ST_IDLE;
        end
      end
      ST_P_LOW: begin
        n.cnt = q.rate;
        if (!sda_s) begin
          n.st = ST_P_SCL;
        end
      end
      ST_P_SCL: begin
        n.cnt = q.rate;
        if (scl_s) begin
          n.st = ST_P_CNT;
        end
      end
      ST_P_CNT: begin
        if (!scl_s) begin
          col = 1'b1;
        end else if (tz) begin
          n.cnt = q.rate;
          n.st = ST_P_SDA;
        end
      end
      ST_P_SDA: begin
        if (tz) begin
          if (!sda_s) begin
            col = 1'b1;
          end else begin
            n.hold_sda = 1'b0;
            n.hold_scl = 1'b0;
            n.pen = 1'b0;
            n.evt = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      ST_T_LOW: begin
        if (tz) begin
          n.st = ST_T_REL;
        end
      end
      ST_T_REL: begin
        n.cnt = q.rate;
        if (scl_s) begin
          n.st = ST_T_HIGH;
        end
      end
      ST_T_HIGH: begin
        if (q.sh[8] && !sda_s && !(last && !q.is_ack)) begin
          col = 1'b1;
        end else if (tz) begin
          if (last && !q.is_ack) begin
            n.ackstat = sda_s;
          end
          n.sh = {q.sh[7:0], 1'b0};
          n.left = q.left - BITS_ONE;
          n.cnt = q.rate;
          n.st = ST_T_LOW;
          if (last) begin
            n.bf = 1'b0;
            n.acken = 1'b0;
            n.hold_scl = 1'b1;
            n.evt = 1'b1;
            n.st = ST_IDLE;
          end
        end
      end
      default: n.st = ST_IDLE;
    endcase

    // Collision abort
    if (col) begin
      n.bcl = 1'b1;
      n.st = ST_IDLE;
      n.bf = 1'b0;
      n.hold_sda = 1'b0;
      n.hold_scl = 1'b0;
      n.sen = 1'b0;
      n.rsen = 1'b0;
      n.pen = 1'b0;
      n.acken = 1'b0;
    end

    // Bus monitor keeps running after a collision
    if (start_det) begin
      n.s_seen = 1'b1;
      n.p_seen = 1'b0;
    end
    if (stop_det) begin
      n.p_seen = 1'b1;
      n.s_seen = 1'b0;
      n.evt = 1'b1;
    end
    if (!q.en) begin
      n.s_seen = 1'b0;
      n.p_seen = 1'b0;
      n.st = ST_IDLE;
      n.hold_sda = 1'b0;
      n.hold_scl = 1'b0;
    end

    // Pin drivers from the next state, as {sda, scl} pull-low enables
    case (n.st)
      ST_IDLE: {n.sda_oe, n.scl_oe} = {n.hold_sda, n.hold_scl};
      ST_S_HOLD, ST_R_HOLD, ST_P_SCL, ST_P_CNT: {n.sda_oe, n.scl_oe} = 2'h2;
      ST_R_SDA: {n.sda_oe, n.scl_oe} = 2'h1;
      ST_P_LOW: {n.sda_oe, n.scl_oe} = 2'h3;
      ST_T_LOW: {n.sda_oe, n.scl_oe} = {~n.sh[8], 1'b1};
      ST_T_REL, ST_T_HIGH: {n.sda_oe, n.scl_oe} = {~n.sh[8], 1'b0};
      default: {n.sda_oe, n.scl_oe} = 2'h0;
    endcase
  end

  // State register, frozen while the clock enable is low
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      q <= '0;
    end else if (ce_in) begin
      q <= n;
    end
  end

  // Outputs; open-drain pins only ever pull low
  assign rdata_out = q.rdata;
  assign sda_out = 1'b0;
  assign scl_out = 1'b0;
  assign sda_oe_out = q.sda_oe;
  assign scl_oe_out = q.scl_oe;

  // Checks
  a_lost_bit: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.st == ST_T_HIGH && q.sh[8] && !q.sda_sy[1] && !last
    |=> q.bcl && q.st == ST_IDLE)
    else $error("lost bit not flagged");
  a_col_idle: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && col |=> q.st == ST_IDLE && q.bcl)
    else $error("collision not returned to idle");
  a_col_release: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && col |=> !q.bf && !q.sda_oe && !q.scl_oe)
    else $error("collision left lines or full flag");
  a_col_seq: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && col && !(req_in.wr && req_in.addr == REG_CTRL)
    |=> !(q.sen || q.rsen || q.pen || q.acken))
    else $error("sequence enables survive collision");
  a_stop_event: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.en && stop_det |=> q.evt && q.p_seen)
    else $error("stop on bus not signalled");
  a_start_busy: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.en && q.st == ST_IDLE && q.sen && !(q.sda_sy[1] && q.scl_sy[1])
    |=> q.bcl && !q.sen)
    else $error("start on busy bus not aborted");
  a_start_early: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.en && q.st == ST_S_CNT && !q.sda_sy[1] && q.scl_sy[1]
    |=> q.st == ST_S_HOLD && q.sda_oe)
    else $error("start not driven early");
  a_rs_scl: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.st == ST_R_CNT && !q.scl_sy[1] |=> q.bcl)
    else $error("repeated start clock loss missed");
  a_scl_wait: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && q.en && q.st == ST_T_REL && !q.scl_sy[1] |=> q.cnt == q.rate && q.st == ST_T_REL)
    else $error("count ran while clock held low");
  a_seen_clear: assert property (@(posedge clk_in) disable iff (!rst_n)
    ce_in && !q.en |=> !q.s_seen && !q.p_seen)
    else $error("seen bits not cleared while disabled");

endmodule // imb_master_collision

// ### common/imb_pkg.sv
package imb_pkg;

  // Register indices on the plain register port
  localparam logic [1:0] REG_CTRL   = 2'h0;
  localparam logic [1:0] REG_STATUS = 2'h1;
  localparam logic [1:0] REG_DATA   = 2'h2;
  localparam logic [1:0] REG_RATE   = 2'h3;

  // Control register bit positions
  localparam int CTRL_EN    = 0;
  localparam int CTRL_SEN   = 1;
  localparam int CTRL_RSEN  = 2;
  localparam int CTRL_PEN   = 3;
  localparam int CTRL_ACKEN = 4;
  localparam int CTRL_ACKDT = 5;

  // Status register bit positions
  localparam int STAT_BCL   = 0;
  localparam int STAT_EVT   = 1;
  localparam int STAT_BF    = 2;
  localparam int STAT_SSEEN = 3;
  localparam int STAT_PSEEN = 4;
  localparam int STAT_ACK   = 5;
  localparam int STAT_BUSY  = 6;

  // Widths and counts
  localparam int RATE_W = 7;
  localparam logic [RATE_W-1:0] CNT_ZERO = 7'h00;
  localparam logic [RATE_W-1:0] CNT_ONE  = 7'h01;
  localparam logic [3:0] BITS_BYTE = 4'h9;
  localparam logic [3:0] BITS_ACK  = 4'h1;
  localparam logic [3:0] BITS_ONE  = 4'h1;

  // Sequencer states
  typedef enum logic [3:0] {
    ST_IDLE, ST_S_CNT, ST_S_HOLD, ST_R_SDA, ST_R_SCL, ST_R_CNT, ST_R_HOLD,
    ST_P_LOW, ST_P_SCL, ST_P_CNT, ST_P_SDA, ST_T_LOW, ST_T_REL, ST_T_HIGH
  } imb_state_type;

  // Register port request group
  typedef struct packed {
    logic [1:0] addr;
    logic [7:0] wdata;
    logic       wr;
    logic       rd;
  } imb_req_type;

  // Complete block state
  typedef struct packed {
    logic [1:0]        sda_sy;
    logic [1:0]        scl_sy;
    logic              sda_p;
    logic              scl_p;
    imb_state_type     st;
    logic [RATE_W-1:0] cnt;
    logic [8:0]        sh;
    logic [3:0]        left;
    logic              is_ack;
    logic              en;
    logic              sen;
    logic              rsen;
    logic              pen;
    logic              acken;
    logic              ackdt;
    logic [RATE_W-1:0] rate;
    logic [7:0]        tbuf;
    logic              bcl;
    logic              evt;
    logic              bf;
    logic              s_seen;
    logic              p_seen;
    logic              ackstat;
    logic              hold_scl;
    logic              hold_sda;
    logic              sda_oe;
    logic              scl_oe;
    logic [7:0]        rdata;
  } imb_regs_type;

endpackage

// ### test/imb_bus_model.sv
`timescale 1ns/100ps
module imb_bus_model (
  // Device pin enables
  input  wire logic sda_oe_in,
  input  wire logic scl_oe_in,
  // Other masters and slaves pulling low, slow clock holder
  input  wire logic pull_sda_in,
  input  wire logic pull_scl_in,
  input  wire logic stretch_in,
  // Wire levels seen by every party
  output logic      sda_out,
  output logic      scl_out
);
  logic hold_scl = 1'b0;

  // Slow party keeps SCL low for 640 ns, one rate count of 16 clocks, after the device lets go
  always @(negedge scl_oe_in) begin
    if (stretch_in) begin
      hold_scl = 1'b1;
      #640;
      hold_scl = 1'b0;
    end
  end

  // Open-drain wired-AND with pull-ups: a released line goes high
  assign sda_out = ~(sda_oe_in | pull_sda_in);
  assign scl_out = ~(scl_oe_in | pull_scl_in | hold_scl);
endmodule // imb_bus_model

// ### test/testbench.sv
`timescale 1ns/100ps
module testbench;
  import imb_pkg::*;
  localparam logic [7:0] CLR = (8'h01 << STAT_BCL) | (8'h01 << STAT_EVT);
  logic        clk_in;
  logic        arst_n_in;
  logic        ce_in;
  imb_req_type req;
  logic [7:0]  rdata;
  logic        sda, scl, sda_oe, scl_oe;
  logic        pull_sda, pull_scl, stretch;
  logic [7:0]  d;
  int          n;
  int          mismatches;
  int          compares;

  imb_master_collision i_dut (
    .clk_in(clk_in), .arst_n_in(arst_n_in), .ce_in(ce_in), .req_in(req),
    .rdata_out(rdata), .sda_in(sda), .scl_in(scl), .sda_out(), .sda_oe_out(sda_oe),
    .scl_out(), .scl_oe_out(scl_oe));

  imb_bus_model i_bus (
    .sda_oe_in(sda_oe), .scl_oe_in(scl_oe), .pull_sda_in(pull_sda),
    .pull_scl_in(pull_scl), .stretch_in(stretch), .sda_out(sda), .scl_out(scl));

  // 25 MHz system clock
  initial clk_in = 1'b0;
  always #20 clk_in = ~clk_in;

  function automatic logic [7:0] ctl(input int p);
    return 8'h01 | (8'h01 << p);
  endfunction

  // Register port cycles
  task automatic wr(input logic [1:0] a, input logic [7:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: v, wr: 1'b1, rd: 1'b0};
    @(posedge clk_in);
    req.wr <= 1'b0;
  endtask

  task automatic rd(input logic [1:0] a, output logic [7:0] v);
    @(posedge clk_in);
    req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk_in);
    req.rd <= 1'b0;
    #1;
    v = rdata;
  endtask

  task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task automatic bit_chk(input string name, input logic [1:0] a, input int p, input logic e);
    logic [7:0] v;
    rd(a, v);
    check(name, {7'h00, v[p]}, {7'h00, e});
  endtask

  // Bounded waits on a status bit or a pin enable
  task automatic poll(input int p);
    for (int i = 0; i < 200; i++) begin
      rd(REG_STATUS, d);
      if (d[p] === 1'b1) break;
    end
  endtask

  task automatic wait_oe(input logic on_scl, input logic lvl);
    for (int i = 0; i < 200; i++) begin
      @(posedge clk_in);
      #1;
      if ((on_scl ? scl_oe : sda_oe) === lvl) break;
    end
  endtask

  task automatic start_ok();
    repeat (4) @(posedge clk_in);
    wr(REG_STATUS, CLR);
    wr(REG_CTRL, ctl(CTRL_SEN));
    poll(STAT_EVT);
    wr(REG_STATUS, CLR);
  endtask

  task automatic tally_and_finish();
    if (mismatches == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask

  // Watchdog against a hung sequence
  initial begin
    repeat (40000) @(posedge clk_in);
    mismatches++;
    $display("ERROR watchdog expected done seen timeout");
    tally_and_finish();
  end

  // Main sequence
  initial begin
    arst_n_in = 1'b0;
    ce_in = 1'b1;
    req = '0;
    pull_sda = 1'b0;
    pull_scl = 1'b0;
    stretch = 1'b0;
    mismatches = 0;
    compares = 0;
    repeat (20) @(posedge clk_in);
    arst_n_in <= 1'b1;
    repeat (4) @(posedge clk_in);
    rd(REG_STATUS, d);
    check("status_reset", d, 8'h40);
    wr(REG_RATE, 8'h10);
    wr(REG_CTRL, 8'h01); // Enable first; sequence bits are refused while disabled
    // Start while SDA is already low
    pull_sda <= 1'b1;
    repeat (4) @(posedge clk_in);
    wr(REG_CTRL, ctl(CTRL_SEN));
    poll(STAT_BCL);
    bit_chk("pre_low_bcl", REG_STATUS, STAT_BCL, 1'b1);
    bit_chk("pre_low_sen", REG_CTRL, CTRL_SEN, 1'b0);
    check("pre_low_lines", {6'h00, sda_oe, scl_oe}, 8'h00);
    pull_sda <= 1'b0;
    repeat (4) @(posedge clk_in);
    wr(REG_STATUS, CLR);
    // SCL pulled low during the first start count
    wr(REG_CTRL, ctl(CTRL_SEN));
    repeat (3) @(posedge clk_in);
    pull_scl <= 1'b1;
    poll(STAT_BCL);
    bit_chk("start_scl_bcl", REG_STATUS, STAT_BCL, 1'b1);
    pull_scl <= 1'b0;
    wr(REG_STATUS, CLR);
    // Another master lowers SDA in the first count
    wr(REG_CTRL, ctl(CTRL_SEN));
    repeat (3) @(posedge clk_in);
    pull_sda <= 1'b1;
    n = 0;
    while (sda_oe !== 1'b1 && n < 40) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("early_sda", {7'h00, n < 8}, 8'h01);
    pull_sda <= 1'b0;
    poll(STAT_EVT);
    bit_chk("early_bcl", REG_STATUS, STAT_BCL, 1'b0);
    // Byte of ones lost to a zero
    wr(REG_STATUS, CLR);
    wr(REG_DATA, 8'hff);
    pull_sda <= 1'b1;
    poll(STAT_BCL);
    bit_chk("byte_bcl", REG_STATUS, STAT_BCL, 1'b1);
    bit_chk("byte_bf", REG_STATUS, STAT_BF, 1'b0);
    bit_chk("byte_busy", REG_STATUS, STAT_BUSY, 1'b0);
    check("byte_lines", {6'h00, sda_oe, scl_oe}, 8'h00);
    // New byte starts from its first bit
    wr(REG_STATUS, CLR);
    wr(REG_DATA, 8'h7f);
    #1;
    check("restart_bit", {7'h00, sda_oe}, 8'h01);
    poll(STAT_BCL);
    wr(REG_STATUS, CLR);
    pull_sda <= 1'b0;
    poll(STAT_EVT);
    bit_chk("stop_seen", REG_STATUS, STAT_PSEEN, 1'b1);
    // Clean start, SCL held low by others in the second count
    wr(REG_STATUS, CLR);
    wr(REG_CTRL, ctl(CTRL_SEN));
    wait_oe(1'b0, 1'b1);
    pull_scl <= 1'b1;
    poll(STAT_EVT);
    bit_chk("start2_bcl", REG_STATUS, STAT_BCL, 1'b0);
    bit_chk("start2_sen", REG_CTRL, CTRL_SEN, 1'b0);
    pull_scl <= 1'b0;
    // Repeated start finds SDA low when SCL goes high
    wr(REG_STATUS, CLR);
    wr(REG_CTRL, ctl(CTRL_RSEN));
    wait_oe(1'b1, 1'b0);
    pull_sda <= 1'b1;
    poll(STAT_BCL);
    bit_chk("rep_bcl", REG_STATUS, STAT_BCL, 1'b1);
    bit_chk("rep_rsen", REG_CTRL, CTRL_RSEN, 1'b0);
    pull_sda <= 1'b0;
    // Stop with SCL pulled low during its high count
    start_ok();
    wr(REG_CTRL, ctl(CTRL_PEN));
    wait_oe(1'b1, 1'b0);
    repeat (4) @(posedge clk_in);
    pull_scl <= 1'b1;
    poll(STAT_BCL);
    bit_chk("stop_scl_bcl", REG_STATUS, STAT_BCL, 1'b1);
    bit_chk("stop_pen", REG_CTRL, CTRL_PEN, 1'b0);
    check("stop_lines", {6'h00, sda_oe, scl_oe}, 8'h00);
    pull_scl <= 1'b0;
    // Clean stop against a slow clock holder
    start_ok();
    stretch <= 1'b1;
    wr(REG_CTRL, ctl(CTRL_PEN));
    wait_oe(1'b1, 1'b0);
    n = 0;
    while (sda_oe !== 1'b0 && n < 100) begin
      @(posedge clk_in);
      #1;
      n++;
    end
    check("scl_high_wait", {7'h00, n >= 33}, 8'h01);
    poll(STAT_EVT);
    // The bus stop sets the event early; let the final count finish
    repeat (20) @(posedge clk_in);
    bit_chk("stop_ok_bcl", REG_STATUS, STAT_BCL, 1'b0);
    bit_chk("stop_ok_p", REG_STATUS, STAT_PSEEN, 1'b1);
    bit_chk("stop_ok_pen", REG_CTRL, CTRL_PEN, 1'b0);
    stretch <= 1'b0;
    // Stop finds SDA low at the end of its count
    start_ok();
    wr(REG_CTRL, ctl(CTRL_PEN));
    wait_oe(1'b1, 1'b0);
    wait_oe(1'b0, 1'b0);
    pull_sda <= 1'b1;
    poll(STAT_BCL);
    bit_chk("stop_sda_bcl", REG_STATUS, STAT_BCL, 1'b1);
    pull_sda <= 1'b0;
    // Clean repeated start, another master lowers SDA inside the high count
    start_ok();
    wr(REG_CTRL, ctl(CTRL_RSEN));
    wait_oe(1'b1, 1'b0);
    repeat (6) @(posedge clk_in);
    pull_sda <= 1'b1;
    poll(STAT_EVT);
    bit_chk("rep_ok_bcl", REG_STATUS, STAT_BCL, 1'b0);
    bit_chk("rep_ok_rsen", REG_CTRL, CTRL_RSEN, 1'b0);
    check("rep_ok_lines", {6'h00, sda_oe, scl_oe}, 8'h03);
    pull_sda <= 1'b0;
    // Disabling clears the seen bits
    repeat (6) @(posedge clk_in);
    wr(REG_CTRL, 8'h00);
    rd(REG_STATUS, d);
    check("disabled_seen", d & 8'h18, 8'h00);
    tally_and_finish();
  end
endmodule // testbench
